// ==== rtl/elsfr_pkg.sv ====
// Constants shared by the link service framer: frame header codes,
// descriptor layout, register map and status bit positions.
// Assumes a 32-bit payload word stream and an APB register port.
package elsfr_pkg;
    // ==========================================================
    // Frame header codes
    localparam logic [7:0]  ELS_TYPE        = 8'h01;
    localparam logic [3:0]  ROUTE_ELS       = 4'h2;
    localparam logic [3:0]  INFO_SOL_DATA   = 4'h1;
    localparam logic [3:0]  INFO_REQUEST    = 4'h2;
    localparam logic [3:0]  INFO_REPLY      = 4'h3;
    localparam logic [7:0]  CMD_ACCEPT      = 8'h02;
    // ==========================================================
    // Descriptor layout
    localparam logic [31:0] TAG_REQ_INFO    = 32'h0000_0001;
    localparam logic [31:0] LEN_REQ_INFO    = 32'h0000_0004;
    localparam logic [31:0] LEN_VENDOR      = 32'h0000_0008;
    localparam logic [31:0] LIST_REQ_INFO   = 32'h0000_000C;
    localparam logic [31:0] LIST_VENDOR     = 32'h0000_0010;
    localparam logic [31:0] DESC_HDR_BYTES  = 32'h0000_0008;
    localparam logic [7:0]  ASCII_SPACE     = 8'h20;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_STATUS      = 8'h04;
    localparam logic [7:0]  OFS_CMD         = 8'h08;
    localparam logic [7:0]  OFS_DESC_CNT    = 8'h0C;
    localparam logic [7:0]  OFS_VEND_HI     = 8'h10;
    localparam logic [7:0]  OFS_VEND_LO     = 8'h14;
    localparam logic [7:0]  OFS_VEND_LEN    = 8'h18;
    localparam logic [7:0]  OFS_VEND_TAG    = 8'h1C;
    // Control bits.
    localparam int CTL_REPLY_EN  = 0;
    localparam int CTL_TLV_MODE  = 1;
    localparam int CTL_ZONE_ACT  = 2;
    localparam int CTL_VEND_EN   = 3;
    localparam int CTL_CSU_EN    = 4;
    localparam logic [4:0]  CTRL_RESET      = 5'h01;
    // Status bits, sticky, write one to clear.
    localparam int ST_TYPE       = 0;
    localparam int ST_ROUTE      = 1;
    localparam int ST_INFO       = 2;
    localparam int ST_W0_RSVD    = 3;
    localparam int ST_ALIGN      = 4;
    localparam int ST_OVERRUN    = 5;
    localparam int ST_BITS       = 6;
    localparam logic [3:0]  VEND_LEN_RESET  = 4'h8;
endpackage

// ==== rtl/elsfr_vendor_pad.sv ====
// Pads a vendor identification string of one to eight characters.
// Assumes character zero sits in the top byte of chars.
`timescale 1ns/1ps
`default_nettype none
module elsfr_vendor_pad
    import elsfr_pkg::*;
(
    input  wire logic [63:0] chars,
    input  wire logic [3:0]  count,
    output logic      [63:0] padded
);
    // ==========================================================
    // Per byte select
    for (genvar i = 0; i < 8; i++) begin : g_byte
        // Byte i counted from the most significant end.
        assign padded[63-8*i -: 8] = (4'(i) < count) ? chars[63-8*i -: 8]
                                                      : ASCII_SPACE;
    end
endmodule // elsfr_vendor_pad
`default_nettype wire

// ==== rtl/elsfr_framer.sv ====
// Link service framer: checks received request and reply sequences,
// walks descriptor lists, and sends an accept reply with descriptors.
// Assumes payload words arrive one per cycle, synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module elsfr_framer
    import elsfr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    input  wire logic        rx_first_frame,
    input  wire logic        rx_last_frame,
    input  wire logic [7:0]  rx_r_ctl,
    input  wire logic [7:0]  rx_type,
    input  wire logic [15:0] rx_ox_id,
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_zone_match,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [31:0]      tx_data,
    output logic [7:0]       tx_r_ctl,
    output logic [7:0]       tx_type,
    output logic [15:0]      tx_ox_id,
    output logic             tx_first,
    output logic             tx_last,
    output logic             tx_last_seq
);
    // ==========================================================
    // Register file
    logic [4:0]          ctrl_q;
    logic [ST_BITS-1:0]  sts_q;
    logic [ST_BITS-1:0]  sts_set;
    logic [31:0]         cmd_q;
    logic [15:0]         desc_cnt_q;
    logic [63:0]         vend_q;
    logic [3:0]          vend_len_q;
    logic [31:0]         vend_tag_q;
    logic                wr_en;
    logic                rd_hit;

    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_hit  = (paddr[7:5] == 3'b000) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !rd_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= CTRL_RESET;
            vend_q     <= 64'h2020_2020_2020_2020;
            vend_len_q <= VEND_LEN_RESET;
            vend_tag_q <= 32'h0000_0000;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CTRL:     ctrl_q     <= pwdata[4:0];
                OFS_VEND_HI:  vend_q[63:32] <= pwdata;
                OFS_VEND_LO:  vend_q[31:0]  <= pwdata;
                OFS_VEND_LEN: vend_len_q <= pwdata[3:0];
                OFS_VEND_TAG: vend_tag_q <= pwdata;
                default: ;
            endcase
        end
    end

    // A new error in the same cycle as a clear stays set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= '0;
        end else begin
            sts_q <= (sts_q & ~((wr_en && paddr == OFS_STATUS)
                                ? pwdata[ST_BITS-1:0] : '0)) | sts_set;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            unique case (paddr)
                OFS_CTRL:     prdata = {27'h0, ctrl_q};
                OFS_STATUS:   prdata = {{(32-ST_BITS){1'b0}}, sts_q};
                OFS_CMD:      prdata = cmd_q;
                OFS_DESC_CNT: prdata = {16'h0000, desc_cnt_q};
                OFS_VEND_HI:  prdata = vend_q[63:32];
                OFS_VEND_LO:  prdata = vend_q[31:0];
                OFS_VEND_LEN: prdata = {28'h0, vend_len_q};
                OFS_VEND_TAG: prdata = vend_tag_q;
                default:      prdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Receive header checks
    logic       hdr_chk;
    logic       info_ok;
    logic [3:0] rx_info;

    // Only TYPE and R_CTL are interpreted; other header bits are ignored.
    assign hdr_chk = rx_valid && rx_sof;
    assign rx_info = rx_r_ctl[3:0];
    assign info_ok = (rx_info == INFO_REQUEST) || (rx_info == INFO_REPLY)
                  || (rx_info == INFO_SOL_DATA && ctrl_q[CTL_CSU_EN]);

    // ==========================================================
    // Descriptor list walker
    typedef enum logic [2:0] {
        P_CMD  = 3'b000,
        P_LIST = 3'b001,
        P_TAG  = 3'b010,
        P_LEN  = 3'b011,
        P_VAL  = 3'b100,
        P_DONE = 3'b101
    } elsfr_parse_type;

    elsfr_parse_type st_q;
    elsfr_parse_type st_cur;
    logic [31:0]     rem_q;
    logic [29:0]     vwords_q;
    logic [32:0]     pad_len;
    logic            seq_err_q;
    logic            req_seq_q;
    logic            req_done;
    logic            list_end;

    // Each frame after the first continues the payload without a command.
    assign st_cur  = (rx_sof && rx_first_frame) ? P_CMD : st_q;
    assign pad_len = ({1'b0, rx_data} + 33'd3) & ~33'd3;
    // The walk has finished or not begun, or the current word closes the list exactly, so a final word here is clean.
    assign list_end = (st_cur == P_DONE) || (st_cur == P_CMD)
                   || (st_cur == P_LIST && rx_data == 32'h0000_0000)
                   || (st_cur == P_LEN && pad_len == 33'h0 && rem_q == 32'h0000_0000)
                   || (st_cur == P_VAL && vwords_q == 30'h1 && rem_q == 32'h0000_0000);

    always_comb begin
        sts_set = '0;
        if (hdr_chk && rx_type != ELS_TYPE)
            sts_set[ST_TYPE] = 1'b1;
        if (hdr_chk && rx_r_ctl[7:4] != ROUTE_ELS)
            sts_set[ST_ROUTE] = 1'b1;
        if (hdr_chk && !info_ok)
            sts_set[ST_INFO] = 1'b1;
        if (rx_valid && st_cur == P_CMD && ctrl_q[CTL_TLV_MODE]
            && rx_data[23:0] != 24'h00_0000)
            sts_set[ST_W0_RSVD] = 1'b1;
        if (rx_valid && st_cur == P_LIST && rx_data[1:0] != 2'b00)
            sts_set[ST_ALIGN] = 1'b1;
        if (rx_valid && st_cur == P_TAG && rem_q < DESC_HDR_BYTES)
            sts_set[ST_OVERRUN] = 1'b1;
        if (rx_valid && st_cur == P_LEN && pad_len > {1'b0, rem_q})
            sts_set[ST_OVERRUN] = 1'b1;
        if (rx_valid && rx_eof && rx_last_frame && ctrl_q[CTL_TLV_MODE] && !list_end)
            sts_set[ST_OVERRUN] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= P_DONE;
            rem_q      <= 32'h0000_0000;
            vwords_q   <= 30'h0;
            desc_cnt_q <= 16'h0000;
            cmd_q      <= 32'h0000_0000;
        end else if (rx_valid) begin
            unique case (st_cur)
                P_CMD: begin
                    cmd_q      <= rx_data;
                    desc_cnt_q <= 16'h0000;
                    st_q       <= ctrl_q[CTL_TLV_MODE] ? P_LIST : P_DONE;
                end
                P_LIST: begin
                    rem_q <= rx_data;
                    st_q  <= (rx_data == 32'h0 || rx_data[1:0] != 2'b00)
                             ? P_DONE : P_TAG;
                end
                P_TAG: begin
                    rem_q      <= rem_q - DESC_HDR_BYTES;
                    desc_cnt_q <= desc_cnt_q + 16'h0001;
                    st_q       <= (rem_q < DESC_HDR_BYTES) ? P_DONE : P_LEN;
                end
                P_LEN: begin
                    vwords_q <= pad_len[31:2];
                    rem_q    <= rem_q - pad_len[31:0];
                    if (pad_len > {1'b0, rem_q})
                        st_q <= P_DONE;
                    else if (pad_len == 33'h0)
                        st_q <= (rem_q == 32'h0) ? P_DONE : P_TAG;
                    else
                        st_q <= P_VAL;
                end
                P_VAL: begin
                    vwords_q <= vwords_q - 30'h1;
                    if (vwords_q == 30'h1)
                        st_q <= (rem_q == 32'h0) ? P_DONE : P_TAG;
                end
                P_DONE: st_q <= P_DONE;
                default: st_q <= P_DONE;
            endcase
        end
    end

    // Tracks errors and the request category across one sequence.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_err_q <= 1'b0;
            req_seq_q <= 1'b0;
        end else if (rx_valid && rx_sof && rx_first_frame) begin
            seq_err_q <= |sts_set;
            req_seq_q <= (rx_info == INFO_REQUEST);
        end else if (rx_valid) begin
            seq_err_q <= seq_err_q | (|sts_set);
        end
    end

    assign req_done = rx_valid && rx_eof && rx_last_frame
                   && ((rx_sof && rx_first_frame) ? (rx_info == INFO_REQUEST)
                                                  : req_seq_q)
                   && !(|sts_set) && !((rx_sof && rx_first_frame) ? 1'b0
                                                                  : seq_err_q);

    // ==========================================================
    // Accept reply builder
    logic [63:0] vend_pad;
    logic        busy_q;
    logic [3:0]  tx_idx_q;
    logic [3:0]  tx_end;
    logic        with_vend;
    logic [31:0] req_w0_q;

    elsfr_vendor_pad u_pad (
        .chars  (vend_q),
        .count  (vend_len_q),
        .padded (vend_pad)
    );

    // Zoned replies drop the vendor descriptor unless the requester shares a zone.
    assign with_vend = ctrl_q[CTL_VEND_EN]
                    && (!ctrl_q[CTL_ZONE_ACT] || rx_zone_match);
    logic with_vend_q;
    assign tx_end = with_vend_q ? 4'd8 : 4'd4;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q      <= 1'b0;
            tx_idx_q    <= 4'd0;
            tx_ox_id    <= 16'h0000;
            req_w0_q    <= 32'h0000_0000;
            with_vend_q <= 1'b0;
        end else if (!busy_q) begin
            if (req_done && ctrl_q[CTL_REPLY_EN]) begin
                busy_q      <= 1'b1;
                tx_idx_q    <= 4'd0;
                tx_ox_id    <= rx_ox_id;
                req_w0_q    <= (rx_sof && rx_first_frame) ? rx_data : cmd_q;
                with_vend_q <= with_vend;
            end
        end else if (tx_ready) begin
            tx_idx_q <= tx_idx_q + 4'd1;
            if (tx_idx_q == tx_end)
                busy_q <= 1'b0;
        end
    end

    always_comb begin
        unique case (tx_idx_q)
            4'd0: tx_data = {CMD_ACCEPT, 24'h00_0000};
            4'd1: tx_data = with_vend_q ? LIST_REQ_INFO + LIST_VENDOR
                                        : LIST_REQ_INFO;
            4'd2: tx_data = TAG_REQ_INFO;
            4'd3: tx_data = LEN_REQ_INFO;
            4'd4: tx_data = req_w0_q;
            4'd5: tx_data = vend_tag_q;
            4'd6: tx_data = LEN_VENDOR;
            4'd7: tx_data = vend_pad[63:32];
            4'd8: tx_data = vend_pad[31:0];
            default: tx_data = 32'h0000_0000;
        endcase
    end

    assign tx_valid    = busy_q;
    assign tx_r_ctl    = {ROUTE_ELS, INFO_REPLY};
    assign tx_type     = ELS_TYPE;
    assign tx_first    = busy_q && tx_idx_q == 4'd0;
    assign tx_last     = busy_q && tx_idx_q == tx_end;
    assign tx_last_seq = tx_last;

    // ==========================================================
    // Checks
    sequence reply_start_s;
        tx_valid && tx_first;
    endsequence

    sequence req_info_s;
        tx_valid && tx_idx_q == 4'd2 && tx_data == TAG_REQ_INFO;
    endsequence

    type_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        hdr_chk && rx_type != ELS_TYPE |=> sts_q[ST_TYPE])
        else $error("type error not flagged");

    route_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        hdr_chk && rx_r_ctl[7:4] != ROUTE_ELS |=> sts_q[ST_ROUTE])
        else $error("routing error not flagged");

    info_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        hdr_chk && rx_info == 4'h0 |=> sts_q[ST_INFO])
        else $error("reserved info not flagged");

    align_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_valid && st_cur == P_LIST && rx_data[1:0] != 2'b00
        |=> sts_q[ST_ALIGN])
        else $error("list length alignment not flagged");

    reply_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
        req_done && ctrl_q[CTL_REPLY_EN] && !busy_q |=> reply_start_s)
        else $error("request not answered");

    word0_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        reply_start_s |-> tx_data == {CMD_ACCEPT, 24'h00_0000})
        else $error("accept word 0 malformed");

    echo_word_a: assert property (@(posedge pclk) disable iff (!presetn)
        (req_info_s and tx_ready) ##1 tx_ready ##1 1'b1
        |-> tx_data == req_w0_q && tx_idx_q == 4'd4)
        else $error("request word not echoed");

    last_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_last_seq |-> tx_valid && tx_idx_q == tx_end)
        else $error("last sequence bit misplaced");

    exch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid && !tx_first |-> $stable(tx_ox_id))
        else $error("exchange changed during reply");
endmodule // elsfr_framer
`default_nettype wire

// ==== verif/elsfr_remote.sv ====
// Remote port model: sends request sequences word by word and takes
// reply words, stalling every other cycle when slow is set.
// Assumes the framer samples every stream signal on the rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module elsfr_remote (
    input  wire logic        pclk,
    output logic             rx_valid,
    output logic             rx_sof,
    output logic             rx_eof,
    output logic             rx_first_frame,
    output logic             rx_last_frame,
    output logic      [7:0]  rx_r_ctl,
    output logic      [7:0]  rx_type,
    output logic      [15:0] rx_ox_id,
    output logic      [31:0] rx_data,
    output logic             rx_zone_match,
    input  wire logic        tx_valid,
    input  wire logic [31:0] tx_data,
    input  wire logic [7:0]  tx_r_ctl,
    input  wire logic [7:0]  tx_type,
    input  wire logic [15:0] tx_ox_id,
    input  wire logic        tx_first,
    input  wire logic        tx_last,
    input  wire logic        tx_last_seq,
    output logic             tx_ready
);
    logic        slow;
    logic [31:0] got[$];
    logic [34:0] meta[$];

    initial begin
        {rx_valid, rx_sof, rx_eof, rx_first_frame, rx_last_frame} = 5'h00;
        {rx_r_ctl, rx_type, rx_ox_id} = 32'h0000_0000;
        rx_data = 32'h0000_0000;
        rx_zone_match = 1'b0;
        tx_ready = 1'b1;
        slow = 1'b0;
    end

    // ==========================================================
    // Request sender
    task automatic send(input logic [7:0] rc, input logic [7:0] ty, input logic [15:0] ox,
                        input logic zm, input int split, input logic [31:0] w[$]);
        for (int i = 0; i < w.size(); i++) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_sof <= (i == 0) || (i == split);
            rx_eof <= (i == split - 1) || (i == w.size() - 1);
            rx_first_frame <= i < split;
            rx_last_frame <= (i >= split) || (split == w.size());
            rx_r_ctl <= rc;
            rx_type <= ty;
            rx_ox_id <= ox;
            rx_data <= w[i];
            rx_zone_match <= zm;
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        {rx_sof, rx_eof} <= 2'b00;
        // Released data, R_CTL and TYPE lines show the inverse so stale values cannot pass.
        rx_data <= ~w[w.size() - 1];
        rx_r_ctl <= ~rc;
        rx_type <= ~ty;
    endtask

    // ==========================================================
    // Reply sink
    always @(posedge pclk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            meta.push_back({tx_type, tx_r_ctl, tx_ox_id, tx_last_seq, tx_last, tx_first});
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule // elsfr_remote
`default_nettype wire

// ==== verif/tb.sv ====
// Testbench for the link service framer: APB register access, clean
// requests with and without vendor descriptor, and refused requests.
// Assumes elsfr_pkg and the remote port model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import elsfr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rx_data, tx_data;
    logic        rx_valid, rx_sof, rx_eof, rx_first_frame, rx_last_frame, rx_zone_match;
    logic [7:0]  rx_r_ctl, rx_type, tx_r_ctl, tx_type;
    logic [15:0] rx_ox_id, tx_ox_id;
    logic        tx_valid, tx_ready, tx_first, tx_last, tx_last_seq;
    int          errors = 0;
    int          tests_run = 0;
    logic [31:0] req[$];
    logic [31:0] exp[$];
    logic [31:0] r;
    logic        er;
    logic        vend;
    localparam logic [31:0] CCTL [4] = '{32'h0000_0003, 32'h0000_000B, 32'h0000_000F,
                                         32'h0000_000F};
    localparam logic [7:0] ERC [7] = '{8'h22, 8'h32, 8'h20, 8'h21, 8'h22, 8'h22, 8'h22};
    localparam logic [7:0] ETY [7] = '{8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
    localparam logic [7:0] ELO [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    localparam logic [31:0] ELN [7] = '{32'h14, 32'h14, 32'h14, 32'h14, 32'h14, 32'h0D, 32'h08};
    localparam int EBT [7] = '{0, 1, 2, 2, 3, 4, 5};

    elsfr_framer dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rx_valid, .rx_sof, .rx_eof, .rx_first_frame, .rx_last_frame, .rx_r_ctl, .rx_type,
        .rx_ox_id, .rx_data, .rx_zone_match, .tx_valid, .tx_ready, .tx_data, .tx_r_ctl,
        .tx_type, .tx_ox_id, .tx_first, .tx_last, .tx_last_seq
    );
    elsfr_remote rem_u (
        .pclk, .rx_valid, .rx_sof, .rx_eof, .rx_first_frame, .rx_last_frame, .rx_r_ctl,
        .rx_type, .rx_ox_id, .rx_data, .rx_zone_match, .tx_valid, .tx_data, .tx_r_ctl,
        .tx_type, .tx_ox_id, .tx_first, .tx_last, .tx_last_seq, .tx_ready
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t mismatch got %h expected %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd_q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, er);
        chk(er, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b0, a, 32'h0000_0000, r, er);
        chk(r, d);
        chk(er, e);
    endtask

    task automatic mk(input logic [7:0] cmd, input logic [7:0] lo, input logic [31:0] len);
        req = '{{cmd, 16'h0000, lo}, len, 32'h0000_0003, 32'h0000_0003, 32'hAABB_CC00,
                32'h0001_0005, 32'h0000_0000};
    endtask

    task automatic expect_reply(input logic [15:0] ox);
        int n;
        n = 0;
        while (rem_u.got.size() < exp.size() && n < 200) begin
            @(posedge pclk);
            n++;
        end
        repeat (4) @(posedge pclk);
        chk(64'(rem_u.got.size()), 64'(exp.size()));
        for (int i = 0; i < exp.size() && i < rem_u.got.size(); i++) begin
            chk(rem_u.got[i], exp[i]);
            chk(rem_u.meta[i], {8'h01, 8'h23, ox, i == exp.size() - 1, i == exp.size() - 1,
                                i == 0});
        end
        rem_u.got.delete();
        rem_u.meta.delete();
    endtask

    task automatic test_done;
        $display("Checks made %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_CTRL, {27'h0, CTRL_RESET}, 1'b0);
        rd(OFS_STATUS, 32'h0000_0000, 1'b0);
        rd(OFS_VEND_HI, 32'h2020_2020, 1'b0);
        rd(OFS_VEND_LO, 32'h2020_2020, 1'b0);
        rd(OFS_VEND_LEN, {28'h0, VEND_LEN_RESET}, 1'b0);
        rd(OFS_VEND_TAG, 32'h0000_0000, 1'b0);
        rd(8'h20, 32'h0000_0000, 1'b1);
        rd(8'h06, 32'h0000_0000, 1'b1);
        wr(OFS_VEND_HI, 32'h4142_0000);
        wr(OFS_VEND_LEN, 32'h0000_0002);
        wr(OFS_VEND_TAG, 32'h0001_0003);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CTRL, CCTL[c]);
            rem_u.slow = c[0];
            vend = (c == 1) || (c == 2);
            mk(8'h10 + 8'(c), 8'h00, 32'h0000_0014);
            exp = '{32'h0200_0000, vend ? 32'h0000_001C : 32'h0000_000C, 32'h0000_0001,
                    32'h0000_0004, req[0]};
            if (vend) begin
                exp.push_back(32'h0001_0003);
                exp.push_back(32'h0000_0008);
                exp.push_back(32'h4142_2020);
                exp.push_back(32'h2020_2020);
            end
            rem_u.send(8'h22, 8'h01, 16'h1000 + 16'(c), c == 2, c == 3 ? 3 : 7, req);
            expect_reply(16'h1000 + 16'(c));
            rd(OFS_CMD, req[0], 1'b0);
            rd(OFS_DESC_CNT, 32'h0000_0002, 1'b0);
            rd(OFS_STATUS, 32'h0000_0000, 1'b0);
        end
        wr(OFS_CTRL, 32'h0000_0003);
        exp.delete();
        for (int e = 0; e < 7; e++) begin
            mk(8'h40, ELO[e], ELN[e]);
            rem_u.send(ERC[e], ETY[e], 16'h2000, 1'b0, 7, req);
            expect_reply(16'h2000);
            apb(1'b0, OFS_STATUS, 32'h0000_0000, r, er);
            chk(r[EBT[e]], 1'b1);
            wr(OFS_STATUS, 32'h0000_003F);
            rd(OFS_STATUS, 32'h0000_0000, 1'b0);
        end
        wr(OFS_CTRL, 32'h0000_0013);
        mk(8'h40, 8'h00, 32'h0000_0014);
        rem_u.send(8'h21, 8'h01, 16'h3000, 1'b0, 7, req);
        expect_reply(16'h3000);
        rd(OFS_STATUS, 32'h0000_0000, 1'b0);
        test_done();
    end

    // ==========================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
endmodule // tb
`default_nettype wire
